//--- wdg_defs.svh
// Register map, field positions, reset values and timing counts of the guard timer.
//
// Contract
// - After any reset the guard timer is disabled; setting bit 7 starts it.
// - Once enabled, writes clearing the enable bit are ignored until reset.
// - Period field bits 1:0 pick 2^27, 2^25, 2^22 or 2^18 counts.
// - Clock field bits 4:3 pick system clock (00) or real-time source (01).
// - Real-time source is the 32 kHz oscillator or line input, per RTC bit.
// - Every time-out sets the read-only reset-cause flag at control bit 5.
// - Bit 6 clear: time-out resets the chip; set: time-out raises NMI.
// - The reset-cause flag is set on time-out in NMI mode as well.
// - Reset-cause flag survives a guard reset; only other resets clear it.
// - A pollable interrupt-cause flag shows an NMI came from a time-out.
// - Reset and NMI outputs change only on a rising clock edge.
// - Writing A5h then 5Ah to the refresh register restarts the count.
// - Any delay between key bytes is fine unless a time-out comes first.
// - Refresh register is eight bits, write-only, reads show no key state.
// - A complete key sequence returns the counter to its initial count.
`ifndef WDG_DEFS_SVH
`define WDG_DEFS_SVH

`define WDG_ADDR_W 12
`define WDG_CTL_IDX 12'h093
`define WDG_KEY_IDX 12'h094
`define WDG_STAT_IDX 12'h095
`define WDG_CTL_ADDR (`WDG_CTL_IDX << 2)
`define WDG_KEY_ADDR (`WDG_KEY_IDX << 2)
`define WDG_STAT_ADDR (`WDG_STAT_IDX << 2)

`define WDG_EN_BIT 7
`define WDG_NMI_SEL_BIT 6
`define WDG_RST_FLAG_BIT 5
`define WDG_CLK_MSB 4
`define WDG_CLK_LSB 3
`define WDG_PER_MSB 1
`define WDG_PER_LSB 0
`define WDG_STAT_NMI_BIT 0
`define WDG_STAT_RUN_BIT 1

`define WDG_CLK_SYS 2'h0
`define WDG_CLK_RTC 2'h1
`define WDG_PERIOD_RST 2'h0
`define WDG_CLK_RST 2'h0

`define WDG_KEY_FIRST 8'ha5
`define WDG_KEY_SECOND 8'h5a

`define WDG_EXP_P0 5'h1b
`define WDG_EXP_P1 5'h19
`define WDG_EXP_P2 5'h16
`define WDG_EXP_P3 5'h12

`define WDG_CNT_W 27
`define WDG_RST_LEN 8'h10

`endif

//--- wdg_pkg.sv
// Types shared by the guard timer modules.
package wdg_pkg;

  typedef enum logic [1:0] {
    WDG_OFF = 2'b00,
    WDG_RUN = 2'b01,
    WDG_RST = 2'b10
  } wdg_state_e;

  typedef enum logic [1:0] {
    WDG_REG_NONE = 2'b00,
    WDG_REG_CTL = 2'b01,
    WDG_REG_KEY = 2'b10,
    WDG_REG_STAT = 2'b11
  } wdg_reg_e;

  typedef struct packed {
    logic [1:0] oscSync;
    logic [1:0] lineSync;
    logic lastLevel;
    logic tick;
  } wdg_tick_s;

endpackage : wdg_pkg

//--- wdg_rtc_tick.sv
// Synchroniser and edge detector turning the real-time source into ticks.
`timescale 1ns/1ps
`default_nettype none
module wdg_rtc_tick
  import wdg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic oscIn,
  input wire logic lineIn,
  input wire logic selLine,
  output logic tick
);

  wdg_tick_s q_ff;
  wdg_tick_s nxt_q;
  logic level;

  // source select
  // Only the second stage of each synchroniser feeds the mux. Flipping
  // selLine may cost or add one tick; that error is far below a period.
  assign level = selLine ? q_ff.lineSync[1] : q_ff.oscSync[1];

  always_comb begin
    nxt_q = q_ff;
    nxt_q.oscSync = {q_ff.oscSync[0], oscIn};
    nxt_q.lineSync = {q_ff.lineSync[0], lineIn};
    nxt_q.lastLevel = level;
    nxt_q.tick = level & ~q_ff.lastLevel;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign tick = q_ff.tick;

endmodule : wdg_rtc_tick
`default_nettype wire

//--- wdg_timer.sv
// Guard timer core with its APB register slave and time-out responses.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defs.svh"
module wdg_timer
  import wdg_pkg::*;
#(
  parameter int unsigned PERIOD_SHIFT = 0
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`WDG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rtcOsc32k,
  input wire logic lineFreqIn,
  input wire logic rtcSrcLine,
  output logic guardResetOut,
  output logic nmiOut
);

  typedef struct packed {
    wdg_state_e st;
    logic enable;
    logic nmiSel;
    logic rstFlag;
    logic [1:0] clkSel;
    logic [1:0] period;
    logic [1:0] actClk;
    logic [1:0] actPeriod;
    logic keyArmed;
    logic [`WDG_CNT_W-1:0] count;
    logic nmiFlag;
    logic [7:0] rstCnt;
    logic rstOut;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } wdg_core_s;

  wdg_core_s q_ff;
  wdg_core_s nxt_q;

  logic rtcTick;
  wdg_reg_e selReg;
  logic setupDone;
  logic wrAcc;
  logic tick;
  logic timeout;
  logic restart;
  logic [7:0] keyByte;

  wdg_rtc_tick u_tick (
    .clock(clock),
    .rst_b(rst_b),
    .oscIn(rtcOsc32k),
    .lineIn(lineFreqIn),
    .selLine(rtcSrcLine),
    .tick(rtcTick)
  );

  function automatic wdg_reg_e decodeReg(
    input logic [`WDG_ADDR_W-1:0] addr
  );
    wdg_reg_e r;
    r = WDG_REG_NONE;
    if (addr == `WDG_CTL_ADDR) begin
      r = WDG_REG_CTL;
    end else if (addr == `WDG_KEY_ADDR) begin
      r = WDG_REG_KEY;
    end else if (addr == `WDG_STAT_ADDR) begin
      r = WDG_REG_STAT;
    end
    return r;
  endfunction : decodeReg

  // Terminal count of a period code, shortened by PERIOD_SHIFT.
  function automatic logic [`WDG_CNT_W-1:0] limitOf(
    input logic [1:0] per
  );
    logic [4:0] e;
    logic [`WDG_CNT_W:0] full;
    e = `WDG_EXP_P0;
    unique case (per)
      2'h0: e = `WDG_EXP_P0;
      2'h1: e = `WDG_EXP_P1;
      2'h2: e = `WDG_EXP_P2;
      2'h3: e = `WDG_EXP_P3;
    endcase
    e = e - 5'(PERIOD_SHIFT);
    full = ({{`WDG_CNT_W{1'b0}}, 1'b1} << e) - 1'b1;
    return full[`WDG_CNT_W-1:0];
  endfunction : limitOf

  function automatic logic [31:0] readValue(
    input wdg_reg_e r,
    input wdg_core_s s
  );
    logic [31:0] v;
    v = 32'h0;
    unique case (r)
      WDG_REG_CTL: begin
        v[`WDG_EN_BIT] = s.enable;
        v[`WDG_NMI_SEL_BIT] = s.nmiSel;
        v[`WDG_RST_FLAG_BIT] = s.rstFlag;
        v[`WDG_CLK_MSB:`WDG_CLK_LSB] = s.clkSel;
        v[`WDG_PER_MSB:`WDG_PER_LSB] = s.period;
      end
      WDG_REG_KEY: begin
        v = 32'h0;
      end
      WDG_REG_STAT: begin
        v[`WDG_STAT_NMI_BIT] = s.nmiFlag;
        v[`WDG_STAT_RUN_BIT] = (s.st == WDG_RUN);
      end
      WDG_REG_NONE: begin
        v = 32'h0;
      end
    endcase
    return v;
  endfunction : readValue

  assign selReg = decodeReg(paddr);
  assign keyByte = pwdata[7:0];

  // Every transfer gets one wait state: pready rises in the second
  // access cycle, so read data and the error flag come from flops.
  assign setupDone = psel & penable & ~q_ff.pready;

  // Writes are dropped while the chip is held in guard reset.
  assign wrAcc = psel & penable & q_ff.pready & pwrite
               & (selReg != WDG_REG_NONE) & (q_ff.st != WDG_RST);

  // count clock select
  // Reserved clock codes fall back to the system clock, so a bad write
  // can never stop the timer.
  assign tick = (q_ff.actClk == `WDG_CLK_RTC) ? rtcTick : 1'b1;

  assign timeout = (q_ff.st == WDG_RUN) & tick
                 & (q_ff.count == limitOf(q_ff.actPeriod));

  always_comb begin
    nxt_q = q_ff;
    restart = 1'b0;

    nxt_q.pready = 1'b0;
    nxt_q.pslverr = 1'b0;
    if (setupDone) begin
      nxt_q.pready = 1'b1;
      nxt_q.prdata = readValue(selReg, q_ff);
      nxt_q.pslverr = (selReg == WDG_REG_NONE);
    end

    if (wrAcc && selReg == WDG_REG_CTL) begin
      nxt_q.enable = q_ff.enable | pwdata[`WDG_EN_BIT];
      nxt_q.nmiSel = pwdata[`WDG_NMI_SEL_BIT];
      nxt_q.clkSel = pwdata[`WDG_CLK_MSB:`WDG_CLK_LSB];
      nxt_q.period = pwdata[`WDG_PER_MSB:`WDG_PER_LSB];
    end

    if (wrAcc && selReg == WDG_REG_KEY) begin
      if (keyByte == `WDG_KEY_FIRST) begin
        nxt_q.keyArmed = 1'b1;
      end else if (keyByte == `WDG_KEY_SECOND && q_ff.keyArmed) begin
        nxt_q.keyArmed = 1'b0;
        restart = 1'b1;
      end else begin
        nxt_q.keyArmed = 1'b0;
      end
    end

    if (wrAcc && selReg == WDG_REG_STAT) begin
      if (pwdata[`WDG_STAT_NMI_BIT]) begin
        nxt_q.nmiFlag = 1'b0;
      end
    end

    unique case (q_ff.st)
      WDG_OFF: begin
        nxt_q.count = '0;
        if (nxt_q.enable) begin
          nxt_q.st = WDG_RUN;
          nxt_q.actClk = nxt_q.clkSel;
          nxt_q.actPeriod = nxt_q.period;
        end
      end
      WDG_RUN: begin
        if (timeout) begin
          nxt_q.rstFlag = 1'b1;
          nxt_q.keyArmed = 1'b0;
          nxt_q.count = '0;
          nxt_q.actClk = nxt_q.clkSel;
          nxt_q.actPeriod = nxt_q.period;
          if (q_ff.nmiSel) begin
            nxt_q.nmiFlag = 1'b1;
          end else begin
            nxt_q.st = WDG_RST;
            nxt_q.rstOut = 1'b1;
            nxt_q.rstCnt = `WDG_RST_LEN - 8'h1;
          end
        end else if (restart) begin
          nxt_q.count = '0;
          nxt_q.actClk = nxt_q.clkSel;
          nxt_q.actPeriod = nxt_q.period;
        end else if (tick) begin
          nxt_q.count = q_ff.count + 1'b1;
        end
      end
      WDG_RST: begin
        if (q_ff.rstCnt == 8'h0) begin
          // flag survives own reset
          // The guard reset clears the block like a chip reset does,
          // except for the cause flag.
          nxt_q.st = WDG_OFF;
          nxt_q.rstOut = 1'b0;
          nxt_q.enable = 1'b0;
          nxt_q.nmiSel = 1'b0;
          nxt_q.clkSel = `WDG_CLK_RST;
          nxt_q.period = `WDG_PERIOD_RST;
          nxt_q.actClk = `WDG_CLK_RST;
          nxt_q.actPeriod = `WDG_PERIOD_RST;
          nxt_q.keyArmed = 1'b0;
          nxt_q.count = '0;
          nxt_q.nmiFlag = 1'b0;
        end else begin
          nxt_q.rstCnt = q_ff.rstCnt - 8'h1;
        end
      end
      default: begin
        nxt_q.st = WDG_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      q_ff <= '0;
      q_ff.st <= WDG_OFF;
      q_ff.clkSel <= `WDG_CLK_RST;
      q_ff.period <= `WDG_PERIOD_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign prdata = q_ff.prdata;
  assign pready = q_ff.pready;
  assign pslverr = q_ff.pslverr;
  assign guardResetOut = q_ff.rstOut;
  assign nmiOut = q_ff.nmiFlag;

endmodule : wdg_timer
`default_nettype wire

//--- wdg_timer_chk.sv
// Port-level assertion checker for the guard timer.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defs.svh"
module wdg_timer_chk
  import wdg_pkg::*;
#(
  parameter int unsigned PERIOD_SHIFT = 0
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`WDG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rtcOsc32k,
  input wire logic lineFreqIn,
  input wire logic rtcSrcLine,
  input wire logic guardResetOut,
  input wire logic nmiOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic stClr;
  logic rdCtl;
  assign stClr = pready && pwrite && paddr == `WDG_STAT_ADDR && pwdata[0];
  assign rdCtl = pready && !pwrite && paddr == `WDG_CTL_ADDR;
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  sequence s_pulse;
    guardResetOut[*8] ##1 guardResetOut[*8] ##1 !guardResetOut;
  endsequence
  a_one_wait: assert property (s_wait |=> s_answer)
    else $error("pready timing wrong");
  a_ready_qual: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_unmap: assert property (pslverr |-> pready &&
    paddr != `WDG_CTL_ADDR && paddr != `WDG_KEY_ADDR &&
    paddr != `WDG_STAT_ADDR) else $error("pslverr on mapped address");
  a_key_blank: assert property (pready && !pwrite &&
    paddr == `WDG_KEY_ADDR |-> prdata == 32'h0)
    else $error("refresh register read not zero");
  a_ctl_width: assert property (rdCtl |-> prdata[31:8] == 24'h0 && !prdata[2])
    else $error("control read has stray bits");
  a_reset_len: assert property ($rose(guardResetOut) |-> s_pulse)
    else $error("reset pulse not 16 cycles");
  a_nmi_holds: assert property (nmiOut && !stClr &&
    !guardResetOut |=> nmiOut)
    else $error("interrupt flag dropped");
  a_quiet_start: assert property ($rose(rst_b) |->
    (!guardResetOut && !nmiOut)[*8])
    else $error("output active after reset");
endmodule : wdg_timer_chk
bind wdg_timer wdg_timer_chk #(.PERIOD_SHIFT(PERIOD_SHIFT)) i_chk (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rtcOsc32k(rtcOsc32k),
  .lineFreqIn(lineFreqIn), .rtcSrcLine(rtcSrcLine),
  .guardResetOut(guardResetOut), .nmiOut(nmiOut));
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the guard timer.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defs.svh"
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin nMismatch++; \
  $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module testbench
  import wdg_pkg::*;
;
  logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, guardResetOut, nmiOut;
  logic rtcOsc32k = 0, lineFreqIn = 0, rtcSrcLine = 0;
  int nMismatch = 0, checksDone = 0, cyc = 0, tGood = 0, tRise = 0;
  wdg_timer #(.PERIOD_SHIFT(14)) i_wdg_timer (.clock(clock), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtcOsc32k(rtcOsc32k), .lineFreqIn(lineFreqIn), .rtcSrcLine(rtcSrcLine),
    .guardResetOut(guardResetOut), .nmiOut(nmiOut));
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (guardResetOut && tRise == 0) tRise <= cyc;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) nMismatch++;
  endtask : xfer
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    `CHK(rd, e)
  endtask : rdchk
  task automatic key(input logic [7:0] b);
    xfer(1, `WDG_KEY_ADDR, {24'h0, b});
  endtask : key
  // Slow pin edges keep each tick apart through the synchroniser.
  task automatic tick(input logic ln, input int n);
    repeat (n) begin
      if (ln) lineFreqIn <= 1;
      else rtcOsc32k <= 1;
      repeat (4) @(posedge clock);
      lineFreqIn <= 0;
      rtcOsc32k <= 0;
      repeat (4) @(posedge clock);
    end
    repeat (6) @(posedge clock);
  endtask : tick
  task automatic complete_run;
    $display("Mismatches %0d of %0d checks", nMismatch, checksDone);
    if (nMismatch == 0 && checksDone > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #5000000;
    nMismatch++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1;
    rdchk(`WDG_CTL_ADDR, 32'h0);
    rdchk(`WDG_KEY_ADDR, 32'h0);
    xfer(0, 12'h000, 0);
    `CHK(er, 1'b1)
    xfer(1, `WDG_CTL_ADDR, 32'h03);
    repeat (40) @(posedge clock);
    `CHK(guardResetOut, 1'b0)
    rdchk(`WDG_CTL_ADDR, 32'h03);
    xfer(1, `WDG_CTL_ADDR, 32'h80);
    xfer(1, `WDG_CTL_ADDR, 32'h00);
    rdchk(`WDG_CTL_ADDR, 32'h80);
    repeat (12) begin
      key(`WDG_KEY_FIRST);
      repeat (600) @(posedge clock);
      key(`WDG_KEY_SECOND);
      tGood = cyc;
      repeat (200) @(posedge clock);
    end
    `CHK(tRise, 0)
    key(`WDG_KEY_FIRST);
    key(8'h33);
    key(`WDG_KEY_SECOND);
    repeat (8400) @(posedge clock);
    `CHK(tRise - tGood inside {[8185:8200]}, 1'b1)
    rdchk(`WDG_CTL_ADDR, 32'h20);
    xfer(1, `WDG_CTL_ADDR, 32'hc3);
    repeat (30) @(posedge clock);
    `CHK(nmiOut, 1'b1)
    `CHK(guardResetOut, 1'b0)
    rdchk(`WDG_STAT_ADDR, 32'h3);
    rdchk(`WDG_CTL_ADDR, 32'he3);
    xfer(1, `WDG_CTL_ADDR, 32'hcb);
    repeat (20) @(posedge clock);
    xfer(1, `WDG_STAT_ADDR, 32'h1);
    repeat (30) @(posedge clock);
    `CHK(nmiOut, 1'b0)
    tick(0, 16);
    `CHK(nmiOut, 1'b1)
    rtcSrcLine <= 1;
    xfer(1, `WDG_STAT_ADDR, 32'h1);
    tick(0, 16);
    `CHK(nmiOut, 1'b0)
    tick(1, 16);
    `CHK(nmiOut, 1'b1)
    rst_b <= 0;
    repeat (3) @(posedge clock);
    rst_b <= 1;
    rdchk(`WDG_CTL_ADDR, 32'h0);
    xfer(1, `WDG_CTL_ADDR, 32'h93);
    repeat (24) @(posedge clock);
    `CHK(guardResetOut, 1'b1)
    complete_run;
  end
endmodule : testbench
`default_nettype wire
